// ### hw/dpss_map.svh
// constants for the profile switch sequencer: register offsets, fields,
// reset values and timing counts.
// assumes a 200 MHz pclk; included by bare name.
`ifndef DPSS_MAP_SVH
`define DPSS_MAP_SVH

// register byte offsets
`define DPSS_CTRL_OFS      12'h000
`define DPSS_NEXT_OFS      12'h004
`define DPSS_CMD_OFS       12'h008
`define DPSS_STAT_OFS      12'h00C
`define DPSS_COEF_OFS      12'h010

// ctrl fields
`define DPSS_CTRL_NPROF_LSB 0
`define DPSS_CTRL_HOP_BIT   4
`define DPSS_CTRL_DIFF_BIT  5
`define DPSS_CTRL_W16_BIT   6
`define DPSS_CTRL_DUPLEX_BIT 7
// next fields
`define DPSS_NEXT_IDX_LSB   0
`define DPSS_NEXT_FMODE_LSB 4
`define DPSS_NEXT_RATIO_LSB 8
// cmd bits
`define DPSS_CMD_CAL_BIT    0
`define DPSS_CMD_SW_BIT     1

`define DPSS_CTRL_RST      32'h0000_0066
`define DPSS_MAX_PROF      3'h6
`define DPSS_MIN_PROF      3'h2
`define DPSS_MAIN_IDX      3'h5

`define DPSS_SWITCH_NS     50000
`define DPSS_CLK_MHZ       200
`define DPSS_SWITCH_CYC    ((`DPSS_SWITCH_NS * `DPSS_CLK_MHZ) / 1000)
`define DPSS_CAL_CYC       64

`endif

// ### hw/dpss_pkg.sv
// types for the profile switch sequencer; only the sequencer end uses them.
// assumes nothing beyond a SystemVerilog compiler.
package dpss_pkg;

    typedef enum logic [2:0] {
        DPSS_ST_IDLE   = 3'b000,
        DPSS_ST_CALM   = 3'b001,
        DPSS_ST_CALD   = 3'b011,
        DPSS_ST_READY  = 3'b010,
        DPSS_ST_SWITCH = 3'b110
    } dpss_state_t;

    typedef enum logic [1:0] {
        DPSS_FIR_OFF     = 2'h0,
        DPSS_FIR_DEFAULT = 2'h1,
        DPSS_FIR_CUSTOM  = 2'h2
    } dpss_fir_mode_t;

    typedef enum logic [1:0] {
        DPSS_CH_STANDBY = 2'h0,
        DPSS_CH_CAL     = 2'h1,
        DPSS_CH_PRIMED  = 2'h2,
        DPSS_CH_ACTIVE  = 2'h3
    } dpss_ch_state_t;

endpackage : dpss_pkg

// ### hw/dpss_if.sv
// apb link between the baseband processor end and the sequencer end,
// plus the channel enable pins the processor drives.
// assumes one pclk domain; the bench ties clock and reset in.
`timescale 1ns/100ps
interface dpss_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  tx_enable;
    logic [3:0]  rx_enable;

    modport proc (
        input  pclk, presetn, prdata, pready, pslverr,
        output psel, penable, pwrite, paddr, pwdata, tx_enable, rx_enable
    );
    modport dev (
        input  pclk, presetn, psel, penable, pwrite, paddr, pwdata,
               tx_enable, rx_enable,
        output prdata, pready, pslverr
    );
endinterface : dpss_if

// ### hw/dpss_dev.sv
// sequencer end: apb registers, calibration passes and the profile
// switch timer; drives the datapath settings on its user side.
// assumes the processor end primes the channels before switching.
`timescale 1ns/100ps
`include "dpss_map.svh"
module dpss_dev #(
    parameter int SWITCH_CYC = `DPSS_SWITCH_CYC,
    parameter int CAL_CYC    = `DPSS_CAL_CYC
) (
    dpss_if.dev         bus,
    output logic [2:0]  active_idx_q,
    output logic [2:0]  decim_shift_q,
    output logic [1:0]  fir_mode_q,
    output logic [31:0] fir_coef_q,
    output logic [7:0]  if_ratio_q,
    output logic [3:0]  tx_on_q,
    output logic [3:0]  rx_on_q,
    output logic        switching_q
);

    dpss_pkg::dpss_state_t state_q;
    logic [31:0] ctrl_q;
    logic [2:0]  next_idx_q;
    logic [1:0]  next_fmode_q;
    logic [7:0]  next_ratio_q;
    logic [31:0] next_coef_q;
    logic [2:0]  cal_idx_q;
    logic [16:0] cnt_q;
    logic        done_q;
    logic        held_q;
    logic        wr;
    logic        rd;
    logic [2:0]  nprof;
    logic        cfg_ok;
    logic        next_ok;
    logic        any_active;
    logic        sw_req;

    assign wr = bus.psel && bus.penable && bus.pwrite;
    assign rd = bus.psel && !bus.pwrite;
    assign nprof = ctrl_q[`DPSS_CTRL_NPROF_LSB +: 3];
    // hopping excludes switching; only 16-bit differential link allowed
    assign cfg_ok = nprof >= `DPSS_MIN_PROF && nprof <= `DPSS_MAX_PROF
        && !ctrl_q[`DPSS_CTRL_HOP_BIT] && ctrl_q[`DPSS_CTRL_DIFF_BIT]
        && ctrl_q[`DPSS_CTRL_W16_BIT];
    // configured profiles are the top n indices, highest rate downward
    // widened sum: five plus a count of six would wrap in three bits
    assign next_ok = next_idx_q <= `DPSS_MAIN_IDX
        && {1'b0, next_idx_q} + {1'b0, nprof} >= 4'h6;
    assign any_active = |bus.tx_enable || |bus.rx_enable;
    assign sw_req = wr && bus.paddr == `DPSS_CMD_OFS
        && bus.pwdata[`DPSS_CMD_SW_BIT];

    ////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped reads zero with error

    assign bus.pready = 1'b1;
    always_comb begin
        bus.pslverr = 1'b0;
        bus.prdata  = 32'h0000_0000;
        if (rd) begin
            case (bus.paddr)
                `DPSS_CTRL_OFS: bus.prdata = ctrl_q;
                `DPSS_NEXT_OFS: bus.prdata = {16'h0000, next_ratio_q,
                    2'h0, next_fmode_q, 1'b0, next_idx_q};
                `DPSS_CMD_OFS:  bus.prdata = 32'h0000_0000;
                `DPSS_STAT_OFS: bus.prdata = {23'h00_0000, held_q,
                    done_q, state_q, active_idx_q, cfg_ok};
                `DPSS_COEF_OFS: bus.prdata = next_coef_q;
                default:        bus.pslverr = bus.penable;
            endcase
        end else if (bus.psel && bus.penable) begin
            bus.pslverr = !(bus.paddr inside {`DPSS_CTRL_OFS,
                `DPSS_NEXT_OFS, `DPSS_CMD_OFS, `DPSS_COEF_OFS});
        end
    end

    // duplex mode, link type and the rest of ctrl are frozen from the calibrate command on
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            ctrl_q <= `DPSS_CTRL_RST;
        end else if (wr && bus.paddr == `DPSS_CTRL_OFS
                     && state_q == dpss_pkg::DPSS_ST_IDLE) begin
            ctrl_q <= bus.pwdata;
        end
    end

    // pending selection taken in every channel state
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            next_idx_q   <= `DPSS_MAIN_IDX;
            next_fmode_q <= 2'h1;
            next_ratio_q <= 8'h01;
            next_coef_q  <= 32'h0000_0000;
        end else if (wr && bus.paddr == `DPSS_NEXT_OFS) begin
            next_idx_q   <= bus.pwdata[`DPSS_NEXT_IDX_LSB +: 3];
            next_fmode_q <= bus.pwdata[`DPSS_NEXT_FMODE_LSB +: 2];
            next_ratio_q <= bus.pwdata[`DPSS_NEXT_RATIO_LSB +: 8];
        end else if (wr && bus.paddr == `DPSS_COEF_OFS) begin
            next_coef_q <= bus.pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequence: main cal, per-profile cal, ready, switch

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            state_q   <= dpss_pkg::DPSS_ST_IDLE;
            cnt_q     <= 17'h0_0000;
            cal_idx_q <= 3'h0;
        end else begin
            case (state_q)
                dpss_pkg::DPSS_ST_IDLE: begin
                    if (wr && bus.paddr == `DPSS_CMD_OFS
                        && bus.pwdata[`DPSS_CMD_CAL_BIT]) begin
                        state_q <= dpss_pkg::DPSS_ST_CALM;
                        cnt_q   <= 17'(CAL_CYC - 1);
                    end
                end
                dpss_pkg::DPSS_ST_CALM: begin
                    if (cnt_q != 17'h0_0000) begin
                        cnt_q <= cnt_q - 17'h0_0001;
                    end else if (cfg_ok) begin
                        state_q   <= dpss_pkg::DPSS_ST_CALD;
                        cnt_q     <= 17'(CAL_CYC - 1);
                        cal_idx_q <= `DPSS_MAIN_IDX;
                    end else begin
                        state_q <= dpss_pkg::DPSS_ST_READY;
                    end
                end
                dpss_pkg::DPSS_ST_CALD: begin
                    if (cnt_q != 17'h0_0000) begin
                        cnt_q <= cnt_q - 17'h0_0001;
                    end else if (cal_idx_q == `DPSS_MAIN_IDX + 3'h1
                                 - nprof) begin
                        state_q <= dpss_pkg::DPSS_ST_READY;
                    end else begin
                        cal_idx_q <= cal_idx_q - 3'h1;
                        cnt_q     <= 17'(CAL_CYC - 1);
                    end
                end
                dpss_pkg::DPSS_ST_READY: begin
                    if ((sw_req || held_q) && cfg_ok && next_ok
                        && !any_active) begin
                        state_q <= dpss_pkg::DPSS_ST_SWITCH;
                        cnt_q   <= 17'(SWITCH_CYC - 1);
                    end
                end
                dpss_pkg::DPSS_ST_SWITCH: begin
                    if (cnt_q != 17'h0_0000) begin
                        cnt_q <= cnt_q - 17'h0_0001;
                    end else begin
                        state_q <= dpss_pkg::DPSS_ST_READY;
                    end
                end
                default: state_q <= dpss_pkg::DPSS_ST_IDLE;
            endcase
        end
    end

    // a request seen while channels are active waits here
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            held_q <= 1'b0;
        end else if (state_q == dpss_pkg::DPSS_ST_SWITCH) begin
            held_q <= 1'b0;
        end else if (sw_req && state_q == dpss_pkg::DPSS_ST_READY) begin
            held_q <= 1'b1;
        end
    end

    // completion flag: set wins over the clear by a new request
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            done_q <= 1'b0;
        end else if (state_q == dpss_pkg::DPSS_ST_SWITCH
                     && cnt_q == 17'h0_0000) begin
            done_q <= 1'b1;
        end else if (sw_req) begin
            done_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // datapath settings, applied to all channels together

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            active_idx_q  <= `DPSS_MAIN_IDX;
            decim_shift_q <= 3'h0;
            fir_mode_q    <= 2'h1;
            fir_coef_q    <= 32'h0000_0000;
            if_ratio_q    <= 8'h01;
        end else if (state_q == dpss_pkg::DPSS_ST_CALD
                     && cnt_q == 17'h0_0000
                     && cal_idx_q == `DPSS_MAIN_IDX + 3'h1 - nprof) begin
            active_idx_q  <= `DPSS_MAIN_IDX;
            decim_shift_q <= 3'h0;
        end else if (state_q == dpss_pkg::DPSS_ST_READY
                     && (sw_req || held_q) && cfg_ok && next_ok
                     && !any_active) begin
            // power-of-two step from main: a shift, not a divider
            active_idx_q  <= next_idx_q;
            decim_shift_q <= `DPSS_MAIN_IDX - next_idx_q;
            fir_mode_q    <= next_fmode_q;
            fir_coef_q    <= next_coef_q;
            if_ratio_q    <= next_ratio_q;
        end
    end

    // enable pins are not followed while switching
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            tx_on_q     <= 4'h0;
            rx_on_q     <= 4'h0;
            switching_q <= 1'b0;
        end else begin
            switching_q <= state_q == dpss_pkg::DPSS_ST_SWITCH;
            if (state_q != dpss_pkg::DPSS_ST_SWITCH) begin
                tx_on_q <= bus.tx_enable;
                rx_on_q <= bus.rx_enable;
            end
        end
    end

endmodule : dpss_dev

// ### hw/dpss_proc.sv
// baseband processor end: apb master that runs one switch request:
// prime channels, write next profile, request switch, poll done.
// assumes the sequencer answers every apb transfer eventually.
`timescale 1ns/100ps
`include "dpss_map.svh"
module dpss_proc (
    dpss_if.proc        bus,
    input  wire logic        go,
    input  wire logic [2:0]  prof_idx,
    input  wire logic [1:0]  fir_mode,
    input  wire logic [7:0]  ratio,
    input  wire logic [3:0]  want_tx,
    input  wire logic [3:0]  want_rx,
    output logic             busy_q,
    output logic             done_q
);

    typedef enum logic [2:0] {
        DPSS_P_IDLE = 3'b000,
        DPSS_P_NEXT = 3'b001,
        DPSS_P_REQ  = 3'b011,
        DPSS_P_POLL = 3'b010,
        DPSS_P_DONE = 3'b110
    } dpss_pstate_t;

    dpss_pstate_t st_q;
    logic         xfer_done;

    assign xfer_done = bus.psel && bus.penable && bus.pready;

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            st_q        <= DPSS_P_IDLE;
            bus.psel    <= 1'b0;
            bus.penable <= 1'b0;
            bus.pwrite  <= 1'b0;
            bus.paddr   <= 12'h000;
            bus.pwdata  <= 32'h0000_0000;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (bus.psel && !bus.penable) begin
                bus.penable <= 1'b1;
            end
            case (st_q)
                DPSS_P_IDLE: begin
                    if (go) begin
                        st_q       <= DPSS_P_NEXT;
                        busy_q     <= 1'b1;
                        bus.psel   <= 1'b1;
                        bus.pwrite <= 1'b1;
                        bus.paddr  <= `DPSS_NEXT_OFS;
                        bus.pwdata <= {16'h0000, ratio, 2'h0, fir_mode,
                                       1'b0, prof_idx};
                    end
                end
                DPSS_P_NEXT: begin
                    if (xfer_done) begin
                        st_q        <= DPSS_P_REQ;
                        bus.penable <= 1'b0;
                        bus.paddr   <= `DPSS_CMD_OFS;
                        bus.pwdata  <= 32'h0000_0002;
                    end
                end
                DPSS_P_REQ: begin
                    if (xfer_done) begin
                        st_q        <= DPSS_P_POLL;
                        bus.penable <= 1'b0;
                        bus.pwrite  <= 1'b0;
                        bus.paddr   <= `DPSS_STAT_OFS;
                    end
                end
                DPSS_P_POLL: begin
                    if (xfer_done) begin
                        bus.penable <= 1'b0;
                        if (bus.prdata[7]) begin
                            st_q     <= DPSS_P_DONE;
                            bus.psel <= 1'b0;
                        end
                    end
                end
                DPSS_P_DONE: begin
                    st_q   <= DPSS_P_IDLE;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                default: st_q <= DPSS_P_IDLE;
            endcase
        end
    end

    // channels held primed for the whole request, enabled otherwise
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            bus.tx_enable <= 4'h0;
            bus.rx_enable <= 4'h0;
        end else if (go || busy_q) begin
            bus.tx_enable <= 4'h0;
            bus.rx_enable <= 4'h0;
        end else begin
            bus.tx_enable <= want_tx;
            bus.rx_enable <= want_rx;
        end
    end

endmodule : dpss_proc

// ### verif/dpss_checker.sv
// assertions on the link between processor end and sequencer end.
// assumes the bench instantiates it beside the sequencer-side interface.
`timescale 1ns/100ps
`include "dpss_map.svh"
module dpss_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  tx_enable,
    input wire logic [3:0]  rx_enable
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    logic mapped;
    logic sw_req;
    logic next_seen_q;
    assign acc    = psel && penable && pready;
    assign rd     = acc && !pwrite;
    assign mapped = paddr inside {`DPSS_CTRL_OFS, `DPSS_NEXT_OFS,
                    `DPSS_CMD_OFS, `DPSS_STAT_OFS, `DPSS_COEF_OFS};
    assign sw_req = acc && pwrite && paddr == `DPSS_CMD_OFS
                    && pwdata[`DPSS_CMD_SW_BIT];
    ////////////////////////////////////////////////////////////
    // a stale selection must never be switched to
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            next_seen_q <= 1'b0;
        else if (acc && pwrite && paddr == `DPSS_NEXT_OFS)
            next_seen_q <= 1'b1;
        else if (sw_req)
            next_seen_q <= 1'b0;
    end
    AST_READY_ONE: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_SETUP_HOLD: assert property (psel && !penable |=> psel && penable
        && $stable(paddr) && $stable(pwrite) && $stable(pwdata))
        else $error("request changed between setup and access");
    AST_ENABLE_DROP: assert property (acc |=> !penable)
        else $error("access phase not ended after ready");
    AST_PRIME_FIRST: assert property (sw_req |->
        tx_enable == 4'h0 && rx_enable == 4'h0)
        else $error("switch requested with channels active");
    AST_NEXT_FIRST: assert property (sw_req |-> next_seen_q)
        else $error("switch requested without next profile");
    AST_UNMAPPED_ERR: assert property (acc && !mapped |->
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    AST_STAT_IDX: assert property (rd && paddr == `DPSS_STAT_OFS |->
        prdata[3:1] <= 3'h5 && prdata[6:4] inside {0, 1, 2, 3, 6})
        else $error("status index or state out of range");
    AST_CMD_READ_ZERO: assert property (rd && paddr == `DPSS_CMD_OFS |->
        prdata == 32'h0)
        else $error("command register read not zero");
endmodule : dpss_checker

// ### verif/dynamic_profile_switch_sequencer_tb.sv
// bench: own apb tasks, then the processor end, share one sequencer
// through a select on the link; short switch and calibration counts.
`timescale 1ns/100ps
`include "dpss_map.svh"
module dynamic_profile_switch_sequencer_tb;
    localparam int SW_CYC  = 20;
    localparam int CAL_CYC = 4;
    logic        pclk, presetn, sel_proc, go, p_busy, p_done, rerr, dv_sw;
    logic        b_psel, b_penable, b_pwrite;
    logic [11:0] b_paddr;
    logic [31:0] b_pwdata, rd, dv_coef;
    logic [3:0]  b_tx, b_rx, want_tx, want_rx, dv_tx, dv_rx;
    logic [2:0]  prof_idx, dv_idx, dv_decim;
    logic [1:0]  fir_mode, dv_fir;
    logic [7:0]  ratio, dv_ratio;
    int          bad_count, n_checks, i, k;
    dpss_if dpss_if_inst (.pclk(pclk), .presetn(presetn));
    dpss_if dpss_if_pr_inst (.pclk(pclk), .presetn(presetn));
    assign dpss_if_inst.psel = sel_proc ? dpss_if_pr_inst.psel : b_psel;
    assign dpss_if_inst.penable = sel_proc ? dpss_if_pr_inst.penable : b_penable;
    assign dpss_if_inst.pwrite = sel_proc ? dpss_if_pr_inst.pwrite : b_pwrite;
    assign dpss_if_inst.paddr = sel_proc ? dpss_if_pr_inst.paddr : b_paddr;
    assign dpss_if_inst.pwdata = sel_proc ? dpss_if_pr_inst.pwdata : b_pwdata;
    assign dpss_if_inst.tx_enable = sel_proc ? dpss_if_pr_inst.tx_enable : b_tx;
    assign dpss_if_inst.rx_enable = sel_proc ? dpss_if_pr_inst.rx_enable : b_rx;
    assign dpss_if_pr_inst.prdata  = dpss_if_inst.prdata;
    assign dpss_if_pr_inst.pready  = dpss_if_inst.pready;
    assign dpss_if_pr_inst.pslverr = dpss_if_inst.pslverr;
    dpss_dev #(.SWITCH_CYC(SW_CYC), .CAL_CYC(CAL_CYC)) dpss_dev_inst (
        .bus(dpss_if_inst), .active_idx_q(dv_idx), .decim_shift_q(dv_decim),
        .fir_mode_q(dv_fir), .fir_coef_q(dv_coef), .if_ratio_q(dv_ratio),
        .tx_on_q(dv_tx), .rx_on_q(dv_rx), .switching_q(dv_sw));
    dpss_proc dpss_proc_inst (
        .bus(dpss_if_pr_inst), .go(go), .prof_idx(prof_idx),
        .fir_mode(fir_mode), .ratio(ratio), .want_tx(want_tx),
        .want_rx(want_rx), .busy_q(p_busy), .done_q(p_done));
    dpss_checker dpss_checker_inst (
        .pclk(pclk), .presetn(presetn), .psel(dpss_if_inst.psel),
        .penable(dpss_if_inst.penable), .pwrite(dpss_if_inst.pwrite),
        .paddr(dpss_if_inst.paddr), .pwdata(dpss_if_inst.pwdata),
        .prdata(dpss_if_inst.prdata), .pready(dpss_if_inst.pready),
        .pslverr(dpss_if_inst.pslverr), .tx_enable(dpss_if_inst.tx_enable),
        .rx_enable(dpss_if_inst.rx_enable));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        logic rdy;
        @(posedge pclk);
        b_psel   <= 1'b1;
        b_pwrite <= wr;
        b_paddr  <= a;
        b_pwdata <= d;
        @(posedge pclk);
        b_penable <= 1'b1;
        // no wait-state limit: only the watchdog ends a stuck access
        do begin
            @(posedge pclk);
            rd   = dpss_if_inst.prdata;
            rerr = dpss_if_inst.pslverr;
            rdy  = dpss_if_inst.pready;
        end while (rdy !== 1'b1);
        b_psel    <= 1'b0;
        b_penable <= 1'b0;
    endtask : apb
    task automatic wait_sw(input logic v);
        for (i = 0; i < 500 && dv_sw !== v; i++)
            @(negedge pclk);
        check({31'h0, dv_sw}, {31'h0, v});
    endtask : wait_sw
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        presetn = 1'b0;
        sel_proc = 1'b0;
        {b_psel, b_penable, b_pwrite, go} = 4'h0;
        b_paddr = 12'h0;
        b_pwdata = 32'h0;
        {b_tx, b_rx, want_tx, want_rx} = 16'h0;
        {prof_idx, fir_mode, ratio} = 13'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check({29'h0, dv_idx}, 32'h5);
        check({30'h0, dv_fir}, 32'h1);
        check({24'h0, dv_ratio}, 32'h1);
        apb(1'b0, `DPSS_CTRL_OFS, 32'h0);
        check(rd, `DPSS_CTRL_RST);
        apb(1'b0, `DPSS_NEXT_OFS, 32'h0);
        check(rd, 32'h0000_0115);
        apb(1'b0, `DPSS_CMD_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, rerr}, 32'h1);
        // hopping on, then single-ended link: config refused
        apb(1'b1, `DPSS_CTRL_OFS, 32'h0000_0073);
        apb(1'b0, `DPSS_STAT_OFS, 32'h0);
        check(rd, 32'h0000_000A);
        apb(1'b1, `DPSS_CTRL_OFS, 32'h0000_0043);
        apb(1'b0, `DPSS_STAT_OFS, 32'h0);
        check(rd, 32'h0000_000A);
        // three profiles, so indices 3 to 5 take part
        apb(1'b1, `DPSS_CTRL_OFS, 32'h0000_0063);
        apb(1'b1, `DPSS_CMD_OFS, 32'h1);
        apb(1'b0, `DPSS_STAT_OFS, 32'h0);
        check(rd, 32'h0000_001B);
        for (k = 0; k < 100 && rd[6:4] !== 3'h2; k++)
            apb(1'b0, `DPSS_STAT_OFS, 32'h0);
        check(rd, 32'h0000_002B);
        apb(1'b1, `DPSS_CTRL_OFS, 32'h0000_0076);
        apb(1'b0, `DPSS_CTRL_OFS, 32'h0);
        check(rd, 32'h0000_0063);
        apb(1'b1, `DPSS_NEXT_OFS, 32'h0000_0402);
        apb(1'b1, `DPSS_CMD_OFS, 32'h2);
        apb(1'b0, `DPSS_STAT_OFS, 32'h0);
        check(rd, 32'h0000_012B);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, `DPSS_COEF_OFS, 32'hC0EF_0000 + k);
            // first pass releases the held request from above
            apb(1'b1, `DPSS_NEXT_OFS, {16'h0, 8'h4 >> k, 2'h0, k[1:0],
                1'b0, 3'h3 + k[2:0]});
            if (k != 0)
                apb(1'b1, `DPSS_CMD_OFS, 32'h2);
            wait_sw(1'b1);
            @(posedge pclk);
            b_tx <= 4'hF;
            repeat (3) @(negedge pclk);
            check({28'h0, dv_tx}, 32'h0);
            wait_sw(1'b0);
            repeat (2) @(negedge pclk);
            check({28'h0, dv_tx}, 32'hF);
            check({29'h0, dv_idx}, {29'h0, 3'h3 + k[2:0]});
            check({29'h0, dv_decim}, {29'h0, 3'h2 - k[2:0]});
            check({30'h0, dv_fir}, {30'h0, k[1:0]});
            check(dv_coef, 32'hC0EF_0000 + k);
            check({24'h0, dv_ratio}, {24'h0, 8'h4 >> k});
            @(posedge pclk);
            b_tx <= 4'h0;
            apb(1'b0, `DPSS_STAT_OFS, 32'h0);
            check(rd, 32'h0000_00A1 | {28'h0, 3'h3 + k[2:0], 1'b0});
        end
        @(posedge pclk);
        sel_proc <= 1'b1;
        want_tx <= 4'hF;
        want_rx <= 4'h3;
        prof_idx <= 3'h4;
        fir_mode <= 2'h1;
        ratio <= 8'h2;
        repeat (3) @(negedge pclk);
        check({28'h0, dpss_if_inst.tx_enable}, 32'hF);
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(negedge pclk);
        check({31'h0, p_busy}, 32'h1);
        for (i = 0; i < 2000 && p_done !== 1'b1; i++)
            @(negedge pclk);
        check({31'h0, p_done}, 32'h1);
        check({31'h0, p_busy}, 32'h0);
        check({29'h0, dv_idx}, 32'h4);
        repeat (3) @(negedge pclk);
        check({28'h0, dpss_if_inst.rx_enable}, 32'h3);
        check({28'h0, dv_rx}, 32'h3);
        report_and_stop();
    end
endmodule : dynamic_profile_switch_sequencer_tb
